// ===== rtl/adccfg_pkg.sv
// constants, field layout and types of the converter setup and comparator block
// Contract
// RQ1: writing one to status/start begins a conversion only while powered down
// RQ2: status/start reads zero while converting, one otherwise
// RQ3: three-bit input select picks the input pair or input against ground
// RQ4: single-channel variant ignores input select, always input 0 against input 1
// RQ5: three-bit gain field sets full scale; codes 110b and 111b equal 101b
// RQ6: mode bit zero is continuous conversion, one is single-shot with power-down
// RQ7: three-bit rate field sets 8 to 860 samples per second
// RQ8: comparator-type bit selects traditional at zero, window at one
// RQ9: polarity bit makes alert active low at zero, active high at one
// RQ10: without latch the alert deasserts once results are back within limits
// RQ11: with latch the alert holds until conversion data read or alert response
// RQ12: on alert response an asserting device offers its address, lowest wins; the code offers it only with the latch bit set
// RQ13: queue field 11b disables comparator and floats the alert pin
// RQ14: queue field needs one, two or four successive exceeding results
// RQ15: controller writes pointer 01b before reaching the setup register
// RQ16: each result is compared with signed upper and lower limit registers
// RQ17: ready signalling when upper limit top bit one and lower top bit zero
// RQ18: ready follows status in single-shot, pulses per result when continuous
// RQ19: after a single-shot conversion the device powers down, status reads one
// RQ20: window counts above upper or below lower; traditional counts above upper only
// RQ21: reset gives status one, input zero, gain 010b, single-shot, rate 100b, disabled
package adccfg_pkg;
   localparam logic [1:0]  PTR_CONV    = 2'h0;
   localparam logic [1:0]  PTR_SETUP   = 2'h1;
   localparam logic [1:0]  PTR_LOWER   = 2'h2;
   localparam logic [1:0]  PTR_UPPER   = 2'h3;
   localparam int          STATUS_BIT  = 15;
   localparam int          MUX_LO      = 12;
   localparam int          GAIN_LO     = 9;
   localparam int          MODE_BIT    = 8;
   localparam int          RATE_LO     = 5;
   localparam int          CMPTYPE_BIT = 4;
   localparam int          POL_BIT     = 3;
   localparam int          LATCH_BIT   = 2;
   localparam int          QUE_LO      = 0;
   localparam logic [15:0] SETUP_RST   = 16'h8583;
   localparam logic [15:0] CONV_RST    = 16'h0000;
   localparam logic [15:0] LOWER_RST   = 16'h8000;
   localparam logic [15:0] UPPER_RST   = 16'h7fff;
   localparam logic [1:0]  QUE_ONE     = 2'h0;
   localparam logic [1:0]  QUE_TWO     = 2'h1;
   localparam logic [1:0]  QUE_OFF     = 2'h3;
   localparam logic [2:0]  GAIN_LAST   = 3'h5;
   localparam logic [1:0]  AIN_0       = 2'h0;
   localparam logic [1:0]  AIN_1       = 2'h1;
   localparam logic [1:0]  AIN_3       = 2'h3;
   localparam int          CLK_HZ      = 200_000_000;
   localparam int          CLK_MHZ     = 200;
   localparam int          SPS_TBL [8] = '{8, 16, 32, 64, 128, 250, 475, 860};
   localparam logic [24:0] RATE_CYC_DEF [8] = '{
      25'(CLK_HZ / SPS_TBL[0]), 25'(CLK_HZ / SPS_TBL[1]),
      25'(CLK_HZ / SPS_TBL[2]), 25'(CLK_HZ / SPS_TBL[3]),
      25'(CLK_HZ / SPS_TBL[4]), 25'(CLK_HZ / SPS_TBL[5]),
      25'(CLK_HZ / SPS_TBL[6]), 25'(CLK_HZ / SPS_TBL[7])};
   localparam int          RDY_PULSE_NS  = 8000;
   localparam logic [10:0] RDY_PULSE_CYC = 11'(RDY_PULSE_NS * CLK_MHZ / 1000);
   typedef enum logic [1:0] {
      ADCCFG_IDLE = 2'b00,
      ADCCFG_CONV = 2'b01
   } adccfg_state_e;
endpackage

// ===== rtl/adccfg_top.sv
// setup register, conversion sequencing and threshold comparator of the converter
module adccfg_top
   import adccfg_pkg::*;
#(
   parameter bit          SINGLE_CH = 1'b0,
   parameter logic [24:0] RATE_CYC [8] = RATE_CYC_DEF
) (
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // register access from the serial front end
   input  wire logic        ptr_wr,
   input  wire logic [7:0]  ptr_wdata,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        gc_reset,
   // alert response arbitration
   input  wire logic        ara_req,
   input  wire logic        ara_won,
   input  wire logic        ara_lost,
   input  wire logic [6:0]  dev_addr,
   output logic             ara_claim,
   output logic      [6:0]  ara_addr,
   // modulator side
   input  wire logic [15:0] res_data,
   output logic             conv_start,
   output logic             conv_busy,
   output logic      [1:0]  ain_pos,
   output logic      [1:0]  ain_neg,
   output logic             ain_neg_gnd,
   output logic      [2:0]  gain_sel,
   output logic      [2:0]  rate_sel,
   // alert/ready pin
   output logic             alert_o,
   output logic             alert_oe
);
   logic [1:0]    rst_sync_r;
   logic          rst_n;
   logic [1:0]    ptr_r, ptr_nxt;
   logic [14:0]   setup_r, setup_nxt;
   logic [15:0]   conv_r, conv_nxt;
   logic [15:0]   lower_r, lower_nxt;
   logic [15:0]   upper_r, upper_nxt;
   adccfg_state_e state_r, state_nxt;
   logic [24:0]   cnt_r, cnt_nxt;
   logic          start_r, start_nxt;
   logic          done;
   logic [2:0]    que_r, que_nxt;
   logic          alert_r, alert_nxt;
   logic [10:0]   rdy_r, rdy_nxt;
   logic          claim_r, claim_nxt;
   logic [6:0]    addr_r, addr_nxt;
   logic          pin_r, pin_nxt;
   logic          oe_r, oe_nxt;
   logic [15:0]   rdata_r, rdata_nxt;
   logic          rvalid_r;
   logic          single, status, cmp_on, ready_mode, exceed, asserted, conv_read;
   logic [2:0]    need;
   logic [2:0]    mux, gain, rate;
   logic [1:0]    que;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   assign mux    = setup_r[MUX_LO +: 3];
   assign gain   = setup_r[GAIN_LO +: 3];
   assign rate   = setup_r[RATE_LO +: 3];
   assign que    = setup_r[QUE_LO +: 2];
   assign single = setup_r[MODE_BIT];
   assign status = (state_r == ADCCFG_IDLE); // RQ2 RQ19
   assign conv_read = reg_rd && (ptr_r == PTR_CONV);

   // register file and conversion sequencer
   always_comb begin
      ptr_nxt   = ptr_r;
      setup_nxt = setup_r;
      conv_nxt  = conv_r;
      lower_nxt = lower_r;
      upper_nxt = upper_r;
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      start_nxt = 1'b0;
      done      = 1'b0;
      if (ptr_wr) begin
         ptr_nxt = ptr_wdata[1:0]; // RQ15
      end
      if (reg_wr) begin
         case (ptr_r)
            PTR_SETUP: setup_nxt = reg_wdata[14:0];
            PTR_LOWER: lower_nxt = reg_wdata;
            PTR_UPPER: upper_nxt = reg_wdata;
            default:   ;
         endcase
      end
      case (state_r)
         ADCCFG_IDLE: begin
            // a start bit written mid-conversion never reaches here, so it is dropped
            if (!setup_nxt[MODE_BIT] ||
                (reg_wr && ptr_r == PTR_SETUP && reg_wdata[STATUS_BIT])) begin // RQ1 RQ6
               state_nxt = ADCCFG_CONV;
               cnt_nxt   = RATE_CYC[setup_nxt[RATE_LO +: 3]] - 25'h1; // RQ7
               start_nxt = 1'b1;
            end
         end
         ADCCFG_CONV: begin
            if (cnt_r != 25'h0) begin
               cnt_nxt = cnt_r - 25'h1;
            end else begin
               done     = 1'b1;
               conv_nxt = res_data;
               if (!setup_r[MODE_BIT]) begin // RQ6
                  cnt_nxt   = RATE_CYC[rate] - 25'h1;
                  start_nxt = 1'b1;
               end else begin
                  state_nxt = ADCCFG_IDLE; // RQ19
               end
            end
         end
         default: state_nxt = ADCCFG_IDLE;
      endcase
      if (gc_reset) begin
         ptr_nxt   = PTR_CONV;
         setup_nxt = SETUP_RST[14:0];
         conv_nxt  = CONV_RST;
         lower_nxt = LOWER_RST;
         upper_nxt = UPPER_RST;
         state_nxt = ADCCFG_IDLE;
         cnt_nxt   = 25'h0;
         start_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r   <= PTR_CONV;
         setup_r <= SETUP_RST[14:0]; // RQ21
         conv_r  <= CONV_RST;
         lower_r <= LOWER_RST;
         upper_r <= UPPER_RST;
         state_r <= ADCCFG_IDLE;
         cnt_r   <= 25'h0;
         start_r <= 1'b0;
      end else if (ce) begin
         ptr_r   <= ptr_nxt;
         setup_r <= setup_nxt;
         conv_r  <= conv_nxt;
         lower_r <= lower_nxt;
         upper_r <= upper_nxt;
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         start_r <= start_nxt;
      end
   end

   // comparator, queue, latch, ready signalling
   always_comb begin
      que_nxt   = que_r;
      alert_nxt = alert_r;
      rdy_nxt   = rdy_r;
      claim_nxt = claim_r;
      addr_nxt  = addr_r;
      cmp_on     = (que != QUE_OFF); // RQ13
      ready_mode = upper_r[15] && !lower_r[15]; // RQ17
      exceed = ($signed(conv_nxt) > $signed(upper_r)) ||
               (setup_r[CMPTYPE_BIT] && ($signed(conv_nxt) < $signed(lower_r))); // RQ8 RQ16 RQ20
      case (que)
         QUE_ONE: need = 3'h1;
         QUE_TWO: need = 3'h2;
         default: need = 3'h4; // RQ14
      endcase
      // clears first, so a result landing in the same cycle still sets
      if (claim_r && ara_won) begin
         alert_nxt = 1'b0; // RQ11
         claim_nxt = 1'b0;
      end
      if (claim_r && ara_lost) begin
         claim_nxt = 1'b0;
      end
      if (conv_read) begin
         alert_nxt = 1'b0; // RQ11
      end
      if (ara_req && alert_r && setup_r[LATCH_BIT]) begin
         claim_nxt = 1'b1; // RQ12
         addr_nxt  = dev_addr;
      end
      if (rdy_r != 11'h0) begin
         rdy_nxt = rdy_r - 11'h1;
      end
      if (done && ready_mode && !single) begin
         rdy_nxt = RDY_PULSE_CYC; // RQ18
      end
      if (done && !ready_mode) begin
         if (exceed) begin
            if (que_r != 3'h7) begin
               que_nxt = que_r + 3'h1;
            end
            if (que_r >= need - 3'h1) begin
               alert_nxt = 1'b1; // RQ14
            end
         end else begin
            que_nxt = 3'h0;
            if (!setup_r[LATCH_BIT]) begin
               alert_nxt = 1'b0; // RQ10
            end
         end
      end
      if (!cmp_on || ready_mode || gc_reset) begin
         que_nxt   = 3'h0;
         alert_nxt = 1'b0;
         claim_nxt = 1'b0;
      end
      if (gc_reset) begin
         rdy_nxt = 11'h0;
      end
      if (ready_mode) begin
         asserted = single ? status : (rdy_r != 11'h0); // RQ18
      end else begin
         asserted = alert_r;
      end
      pin_nxt = setup_nxt[POL_BIT] ? asserted : !asserted; // RQ9
      oe_nxt  = (setup_nxt[QUE_LO +: 2] != QUE_OFF); // RQ13
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         que_r   <= 3'h0;
         alert_r <= 1'b0;
         rdy_r   <= 11'h0;
         claim_r <= 1'b0;
         addr_r  <= 7'h00;
         pin_r   <= 1'b1;
         oe_r    <= 1'b0;
      end else if (ce) begin
         que_r   <= que_nxt;
         alert_r <= alert_nxt;
         rdy_r   <= rdy_nxt;
         claim_r <= claim_nxt;
         addr_r  <= addr_nxt;
         pin_r   <= pin_nxt;
         oe_r    <= oe_nxt;
      end
   end

   // read path, answer one cycle after the strobe
   always_comb begin
      case (ptr_r)
         PTR_CONV:  rdata_nxt = conv_r;
         PTR_SETUP: rdata_nxt = {status, setup_r}; // RQ2
         PTR_LOWER: rdata_nxt = lower_r;
         default:   rdata_nxt = upper_r;
      endcase
      if (!reg_rd) begin
         rdata_nxt = rdata_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r  <= 16'h0000;
         rvalid_r <= 1'b0;
      end else if (ce) begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= reg_rd;
      end
   end

   // input pair decode; the single-channel part has one fixed pair
   always_comb begin
      ain_pos     = AIN_0;
      ain_neg     = AIN_1;
      ain_neg_gnd = 1'b0;
      if (!SINGLE_CH) begin // RQ4
         case (mux) // RQ3
            3'h0:    ain_neg = AIN_1;
            3'h1:    ain_neg = AIN_3;
            3'h2:    begin ain_pos = AIN_1; ain_neg = AIN_3; end
            3'h3:    begin ain_pos = 2'h2; ain_neg = AIN_3; end
            default: begin ain_pos = mux[1:0]; ain_neg = AIN_0; ain_neg_gnd = 1'b1; end
         endcase
      end
   end

   assign gain_sel   = (gain > GAIN_LAST) ? GAIN_LAST : gain; // RQ5
   assign rate_sel   = rate; // RQ7
   assign conv_start = start_r;
   assign conv_busy  = !status;
   assign reg_rdata  = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign ara_claim  = claim_r;
   assign ara_addr   = addr_r;
   assign alert_o    = pin_r;
   assign alert_oe   = oe_r;
endmodule

// ===== tb/adccfg_top_asserts.sv
// concurrent checks on the ports of the setup and comparator block
module adccfg_top_asserts
   import adccfg_pkg::*;
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // register and arbitration ports
   input wire logic       reg_rd,
   input wire logic       reg_rvalid,
   input wire logic       ara_req,
   input wire logic       ara_won,
   input wire logic [6:0] dev_addr,
   input wire logic       ara_claim,
   input wire logic [6:0] ara_addr,
   // modulator side
   input wire logic       conv_start,
   input wire logic       conv_busy,
   input wire logic [1:0] ain_neg,
   input wire logic       ain_neg_gnd,
   input wire logic [2:0] gain_sel
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_start_busy: assert property (conv_start |-> conv_busy)
      else $error("start seen without busy");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("start held over two cycles");
   a_busy_min: assert property ($rose(conv_busy) |-> conv_busy[*8])
      else $error("conversion ended too early");
   a_gain_range: assert property (gain_sel <= GAIN_LAST)
      else $error("gain code above last range");
   a_pair_neg: assert property (!ain_neg_gnd |-> ain_neg == AIN_1 || ain_neg == AIN_3)
      else $error("bad negative input of a pair");
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_claim_cause: assert property ($rose(ara_claim) |-> $past(ara_req))
      else $error("claim without alert response");
   a_claim_addr: assert property (ara_claim |-> ara_addr == dev_addr)
      else $error("claim offers a foreign address");
   a_claim_clear: assert property (ara_won |=> !ara_claim)
      else $error("claim kept after winning");
endmodule

// ===== tb/adccfg_ctrl_model.sv
// register-side controller model: pointer write, then one word access
module adccfg_ctrl_model (
   // clock and answer
   input  wire logic        core_clk,
   input  wire logic [15:0] reg_rdata,
   // requests
   output logic             ptr_wr,
   output logic      [7:0]  ptr_wdata,
   output logic             reg_wr,
   output logic      [15:0] reg_wdata,
   output logic             reg_rd
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      ptr_wr    = 1'b0;
      ptr_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd    = 1'b0;
   end
   // released data lines flip so a stale word never looks live
   task automatic xfer(input logic [1:0] p, input logic wr, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge core_clk);
      #1;
      ptr_wr    = 1'b1;
      ptr_wdata = {6'h00, p};
      @(posedge core_clk);
      #1;
      ptr_wr    = 1'b0;
      ptr_wdata = ~ptr_wdata;
      reg_wr    = wr;
      reg_rd    = !wr;
      reg_wdata = d;
      @(posedge core_clk);
      #1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = ~d;
      q         = reg_rdata;
   endtask
endmodule

// ===== tb/adc_setup_and_comparator_test.sv
// self-checking bench for the setup and comparator block
module adc_setup_and_comparator_test;
   import adccfg_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // short conversions keep the run small
   localparam logic [24:0] RC [8] = '{20, 24, 28, 32, 36, 40, 44, 48};
   logic        core_clk, rstn, gc_reset, ara_req, ara_won, ara_lost;
   logic [15:0] res_data, q;
   wire         ptr_wr, reg_wr, reg_rd, reg_rvalid, conv_start, conv_busy;
   wire         ain_neg_gnd, alert_o, alert_oe, ara_claim;
   wire  [7:0]  ptr_wdata;
   wire  [15:0] reg_wdata, reg_rdata;
   wire  [1:0]  ain_pos, ain_neg;
   wire  [2:0]  gain_sel, rate_sel;
   wire  [6:0]  ara_addr;
   wire  [1:0]  s_pos, s_neg;
   wire         s_gnd;
   int          failures = 0, comparisons = 0, starts = 0, s0, l, l0;
   adccfg_top #(.RATE_CYC(RC)) uut (.core_clk, .rstn, .ce(1'b1), .ptr_wr, .ptr_wdata,
      .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .gc_reset, .ara_req,
      .ara_won, .ara_lost, .dev_addr(7'h48), .ara_claim, .ara_addr, .res_data,
      .conv_start, .conv_busy, .ain_pos, .ain_neg, .ain_neg_gnd, .gain_sel, .rate_sel,
      .alert_o, .alert_oe);
   adccfg_ctrl_model ctrl (.core_clk, .reg_rdata, .ptr_wr, .ptr_wdata, .reg_wr,
      .reg_wdata, .reg_rd);
   // single-channel variant shares all inputs; only its input pair is watched
   adccfg_top #(.RATE_CYC(RC), .SINGLE_CH(1'b1)) uut_single (.core_clk, .rstn, .ce(1'b1),
      .ptr_wr, .ptr_wdata, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata(), .reg_rvalid(),
      .gc_reset, .ara_req, .ara_won, .ara_lost, .dev_addr(7'h48), .ara_claim(),
      .ara_addr(), .res_data, .conv_start(), .conv_busy(), .ain_pos(s_pos),
      .ain_neg(s_neg), .ain_neg_gnd(s_gnd), .gain_sel(), .rate_sel(), .alert_o(),
      .alert_oe());
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (conv_start === 1'b1) starts <= starts + 1;
   task check(input string n, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task wr(input logic [1:0] p, input logic [15:0] d);
      ctrl.xfer(p, 1'b1, d, q);
   endtask
   task rd;
      ctrl.xfer(2'h1, 1'b0, 16'h0000, q);
   endtask
   task idle;
      for (int i = 0; i < 400 && conv_busy !== 1'b0; i++) tick(1);
      if (conv_busy !== 1'b0) begin
         failures++;
         give_verdict;
      end
   endtask
   task conv(input logic [15:0] s, input logic [15:0] r);
      res_data = r;
      wr(2'h1, s);
      idle;
      tick(4);
   endtask
   task pulse_ara(input int k);
      ara_req  = k == 0;
      ara_lost = k == 1;
      ara_won  = k == 2;
      tick(1);
      ara_req  = 1'b0;
      ara_lost = 1'b0;
      ara_won  = 1'b0;
   endtask
   task t_start;
      s0 = starts;
      wr(2'h1, 16'h8583);
      rd;
      check("status", q[15], 1'b0);
      wr(2'h1, 16'h8583);
      idle;
      check("starts", 16'(starts - s0), 16'h0001);
      wr(2'h1, 16'h0583);
      tick(3);
      check("starts", 16'(starts - s0), 16'h0001);
   endtask
   task t_rates;
      for (int r = 0; r < 8; r++) begin
         wr(2'h1, {8'h85, r[2:0], 5'h03});
         l = 1;
         for (int i = 0; i < 300 && conv_busy === 1'b1; i++) begin
            tick(1);
            l++;
         end
         idle;
         if (r == 0) l0 = l;
         check("rate", rate_sel, r[2:0]);
         check("length", 16'(l - l0), 16'(RC[r] - RC[0]));
         rd;
         check("status", q[15], 1'b1);
      end
   endtask
   task t_decode;
      for (int m = 0; m < 8; m++) begin
         wr(2'h1, {1'b0, m[2:0], m[2:0], 9'h183});
         tick(1);
         check("pos", ain_pos, m < 4 ? (m < 2 ? 0 : m - 1) : m - 4);
         check("gnd", ain_neg_gnd, m > 3);
         if (m < 4) check("neg", ain_neg, m == 0 ? 1 : 3);
         check("gain", gain_sel, m > 5 ? 5 : m);
         check("one pos", s_pos, 16'h0000);
         check("one neg", s_neg, 16'h0001);
         check("one gnd", s_gnd, 16'h0000);
         rd;
         check("setup", q, {1'b1, m[2:0], m[2:0], 9'h183});
      end
   endtask
   task t_alert;
      wr(2'h3, 16'h0100);
      wr(2'h2, 16'h0000);
      conv(16'h8588, 16'h0200);
      check("alert", alert_o, 1'b1);
      check("oe", alert_oe, 1'b1);
      conv(16'h8588, 16'h0050);
      check("alert", alert_o, 1'b0);
      conv(16'h8598, 16'hff00);
      check("alert", alert_o, 1'b1);
      conv(16'h8588, 16'hff00);
      check("alert", alert_o, 1'b0);
      conv(16'h8580, 16'h0200);
      check("alert", alert_o, 1'b0);
      conv(16'h8584, 16'h0200);
      conv(16'h8584, 16'h0050);
      check("alert", alert_o, 1'b0);
      pulse_ara(0);
      check("claim", ara_claim, 1'b1);
      check("addr", ara_addr, 16'h0048);
      pulse_ara(1);
      tick(1);
      check("claim", ara_claim, 1'b0);
      pulse_ara(0);
      pulse_ara(2);
      tick(2);
      check("alert", alert_o, 1'b1);
      conv(16'h8589, 16'h0200);
      check("alert", alert_o, 1'b0);
      conv(16'h8589, 16'h0200);
      check("alert", alert_o, 1'b1);
      conv(16'h8584, 16'h0200);
      check("alert", alert_o, 1'b0);
      ctrl.xfer(2'h0, 1'b0, 16'h0000, q);
      check("result", q, 16'h0200);
      tick(1);
      check("alert", alert_o, 1'b1);
      wr(2'h1, 16'h8583);
      tick(2);
      check("oe", alert_oe, 1'b0);
      idle;
      wr(2'h3, 16'h8000);
      conv(16'h8588, 16'h0200);
      check("ready", alert_o, 1'b1);
      wr(2'h1, 16'h8588);
      tick(2);
      check("ready", alert_o, 1'b0);
      idle;
   endtask
   task t_cont;
      s0 = starts;
      wr(2'h1, 16'h0488);
      tick(120);
      check("running", 16'(starts - s0 > 2), 16'h0001);
      check("ready", alert_o, 1'b1);
      wr(2'h1, 16'h0588);
      idle;
      gc_reset = 1'b1;
      tick(1);
      gc_reset = 1'b0;
      rd;
      check("setup", q, SETUP_RST);
   endtask
   initial begin
      rstn     = 1'b0;
      gc_reset = 1'b0;
      ara_req  = 1'b0;
      ara_won  = 1'b0;
      ara_lost = 1'b0;
      res_data = 16'h0000;
      tick(4);
      rstn = 1'b1;
      tick(3);
      rd;
      check("setup", q, SETUP_RST);
      t_start;
      t_rates;
      t_decode;
      t_alert;
      t_cont;
      give_verdict;
   end
endmodule
bind adccfg_top adccfg_top_asserts chk (.core_clk, .rstn, .reg_rd, .reg_rvalid, .ara_req,
   .ara_won, .dev_addr, .ara_claim, .ara_addr, .conv_start, .conv_busy, .ain_neg,
   .ain_neg_gnd, .gain_sel);
